/* File: design/outcond_pkg.sv */
// shared constants and types for the output-terminal conditioning block
package outcond_pkg;
   // quantities arrive as fractions of their own full scale or rated value, Q16 (0x10000=1.0)
   localparam int QW = 18;
   localparam logic [QW-1:0] Q_ONE = 18'h10000;
   // percent of span on outputs: 0..10000 = 0.00%..100.00%
   localparam int PW = 14;
   localparam logic [PW-1:0] SPAN_FULL = 14'h2710;
   // pulse frequency in units of 0.01 kHz
   localparam logic [13:0] PULSE_FLOOR = 14'h0001;
   localparam logic [13:0] PULSE_CEIL = 14'h2710;
   localparam logic [13:0] PULSE_MAX_RESET = 14'h1388;
   // gain in 0.01 units, offset in 0.1 %
   localparam logic signed [11:0] GAIN_RESET = 12'sh064;
   localparam logic signed [11:0] GAIN_MIN = -12'sh3E8;
   localparam logic signed [11:0] GAIN_MAX = 12'sh3E8;
   localparam logic signed [10:0] OFFS_RESET = 11'sh000;
   localparam logic signed [10:0] OFFS_MIN = -11'sh3E8;
   localparam logic signed [10:0] OFFS_MAX = 11'sh3E8;
   // selector defaults
   localparam logic [4:0] SEL_PULSE_RESET = 5'h00;
   localparam logic [4:0] SEL_AO1_RESET = 5'h00;
   localparam logic [4:0] SEL_AO2_RESET = 5'h01;
   // terminal delay in 0.1 s, limit 3600.0 s
   localparam logic [15:0] DELAY_MAX = 16'h8CA0;
   localparam logic [15:0] DELAY_RESET = 16'h0000;
   localparam int TENTH_NS = 100000000;
   localparam int CLK_NS = 10;
   localparam int TENTH_CYCLES = TENTH_NS / CLK_NS;
   localparam logic [4:0] POLARITY_RESET = 5'h00;
   localparam int NTERM = 5;
   // terminal order: 0 pulse-capable dout, 1 relay one, 2 relay three,
   // 3 oc1/relay two, 4 oc2/relay four
   typedef enum logic [4:0] {
      SRC_RUN_FREQ, SRC_SET_FREQ, SRC_CURRENT, SRC_TORQUE_ABS, SRC_POWER,
      SRC_VOLTAGE, SRC_PULSE_IN, SRC_AIN1, SRC_AIN2, SRC_AIN3, SRC_LENGTH,
      SRC_COUNT, SRC_COMM, SRC_SPEED, SRC_CURR_ABS, SRC_VOLT_ABS,
      SRC_TORQUE_SIGNED
   } source_t;
endpackage : outcond_pkg

/* File: design/analog_trim.sv */
// gain, zero offset and clamp for one analog output
`timescale 1ns/1ns
module analog_trim
   import outcond_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [outcond_pkg::PW-1:0] std_pct,
   input wire logic signed [11:0] gain,
   input wire logic signed [10:0] offs,
   output logic [outcond_pkg::PW-1:0] out_pct
);
   logic signed [31:0] next_y;
   always_comb begin
      // y = k*x + b in 0.01 % units; gain is 0.01, offset 0.1 %
      next_y = (32'(signed'({1'b0, std_pct})) * 32'(gain)) / 32'sd100
         + 32'(offs) * 32'sd10;
   end
   always_ff @(posedge clk) begin
      if (!rstn) begin
         out_pct <= '0;
      end else if (next_y < 0) begin
         out_pct <= '0;
      end else if (next_y > 32'(SPAN_FULL)) begin
         out_pct <= SPAN_FULL;
      end else begin
         out_pct <= PW'(next_y);
      end
   end
   a_trim_clamp: assert property (@(posedge clk) disable iff (!rstn)
      out_pct <= SPAN_FULL) else $error("analog output above full scale");
   a_trim_unity: assert property (@(posedge clk) disable iff (!rstn)
      (gain == GAIN_RESET && offs == 0) |=> out_pct == $past(std_pct))
      else $error("unity trim does not pass value");
endmodule : analog_trim

/* File: design/terminal_delay.sv */
// per-terminal delay of the logical function state
`timescale 1ns/1ns
module terminal_delay
   import outcond_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic tick,
   input wire logic func_in,
   input wire logic [15:0] delay,
   output logic func_out
);
   logic [15:0] count;
   logic pending;
   logic [15:0] lim;
   assign lim = (delay > DELAY_MAX) ? DELAY_MAX : delay;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         func_out <= 1'b0;
         count <= '0;
      end else if (func_in == func_out) begin
         count <= '0;
      end else if (lim == '0 || (tick && count + 16'h0001 >= lim)) begin
         func_out <= func_in;
         count <= '0;
      end else if (tick) begin
         count <= count + 16'h0001;
      end
   end
   assign pending = func_in != func_out;
   a_delay_zero: assert property (@(posedge clk) disable iff (!rstn)
      (pending && delay == '0) |=> func_out == $past(func_in))
      else $error("zero delay not immediate");
   a_delay_hold: assert property (@(posedge clk) disable iff (!rstn)
      (pending && delay != '0 && !tick) |=> func_out == $past(func_out))
      else $error("terminal changed without a delay tick");
endmodule : terminal_delay

/* File: design/output_conditioning.sv */
// output-terminal conditioning: source select, scaling, trim, delay, polarity
// Operation
// - pulse output frequency spans floor 0.01 kHz to programmed maximum
// - pulse maximum setting 0.01 to 100.00 kHz, default 50.00 kHz
// - three source selectors, defaults 0, 0 and 1
// - codes 0,1 scale zero to max frequency onto full span
// - codes 2,3,4 full scale at twice rated current, torque, power
// - code 5 full scale at 1.2 times rated voltage
// - code 6 tracks pulse input; codes 7 to 9 track analog inputs
// - codes 10,11 scale length and count to their maxima
// - code 12 passes comm percentage; code 13 scales motor speed
// - code 16 maps minus to plus twice rated torque onto span
// - analog standard full scale is 10 V or 20 mA
// - analog value equals gain times standard plus offset; gain default 1
// - zero offset -100% to +100% of full scale, default zero
// - each digital output waits its own delay, 0 to 3600.0 s
// - five polarity digits, each 0 or 1, default all zeros
// - polarity bit order: pulse dout, relay1, relay3, oc1/relay2, oc2/relay4
// - polarity 0 closes the contact while the function is active
// - polarity 1 opens the contact while the function is active
`timescale 1ns/1ns
module output_conditioning
   import outcond_pkg::*;
(
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic [4:0] PULSE_SOURCE_SEL,
   input wire logic [4:0] AO1_SOURCE_SEL,
   input wire logic [4:0] AO2_SOURCE_SEL,
   input wire logic [13:0] PULSE_MAX_FREQ_SETTING,
   input wire logic signed [11:0] AO1_GAIN,
   input wire logic signed [11:0] AO2_GAIN,
   input wire logic signed [10:0] AO1_OFFSET,
   input wire logic signed [10:0] AO2_OFFSET,
   input wire logic [79:0] TERM_DELAY,
   input wire logic [4:0] OUTPUT_POLARITY_SETTING,
   input wire logic SETTINGS_LOAD,
   input wire logic [17:0] RUN_FREQ_FRAC,
   input wire logic [17:0] SET_FREQ_FRAC,
   input wire logic [17:0] CURRENT_FRAC,
   input wire logic [17:0] TORQUE_FRAC,
   input wire logic TORQUE_NEGATIVE,
   input wire logic [17:0] POWER_FRAC,
   input wire logic [17:0] VOLTAGE_FRAC,
   input wire logic [17:0] PULSE_IN_FRAC,
   input wire logic [17:0] AIN1_FRAC,
   input wire logic [17:0] AIN2_FRAC,
   input wire logic [17:0] AIN3_FRAC,
   input wire logic [17:0] LENGTH_FRAC,
   input wire logic [17:0] COUNT_FRAC,
   input wire logic [13:0] COMM_PCT,
   input wire logic [17:0] SPEED_FRAC,
   input wire logic [4:0] TERM_FUNC,
   output logic [13:0] PULSE_FREQ_OUTPUT,
   output logic [13:0] ANALOG_OUT_FIRST,
   output logic [13:0] ANALOG_OUT_SECOND,
   output logic [4:0] TERM_CLOSED
);
   // ratio inputs: current, torque, power are fractions of rated value,
   // voltage a fraction of rated voltage; others of their own full scale

   logic [4:0] sel_pulse;
   logic [4:0] sel_ao1;
   logic [4:0] sel_ao2;
   logic [13:0] pulse_max;
   logic signed [11:0] gain1;
   logic signed [11:0] gain2;
   logic signed [10:0] offs1;
   logic signed [10:0] offs2;
   logic [15:0] delay [NTERM];
   logic [4:0] polarity;
   logic [PW-1:0] pct_pulse;
   logic [PW-1:0] pct_ao1;
   logic [PW-1:0] pct_ao2;
   logic [26:0] tenth_count;
   logic tick;
   logic [4:0] func_delayed;

   // saturating fraction-to-percent with divisor for the rated multiple
   function automatic logic [PW-1:0] frac_pct(input logic [QW-1:0] f,
                                                input int mul_num,
                                                input int mul_den);
      logic [47:0] p;
      p = (48'(f) * 48'(SPAN_FULL) * 48'(mul_den))
         / (48'(Q_ONE) * 48'(mul_num));
      frac_pct = (p > 48'(SPAN_FULL)) ? SPAN_FULL : PW'(p);
   endfunction : frac_pct

   function automatic logic [PW-1:0] source_pct(input logic [4:0] sel);
      logic [PW-1:0] r;
      logic [PW-1:0] half;
      logic [PW-1:0] t;
      r = '0;
      half = PW'(SPAN_FULL >> 1);
      // beyond twice rated torque the ends hold, no wrap past the span
      t = frac_pct(TORQUE_FRAC, 4, 1);
      if (t > half) begin
         t = half;
      end
      unique case (source_t'(sel))
         SRC_RUN_FREQ: r = frac_pct(RUN_FREQ_FRAC, 1, 1);
         SRC_SET_FREQ: r = frac_pct(SET_FREQ_FRAC, 1, 1);
         SRC_CURRENT: r = frac_pct(CURRENT_FRAC, 2, 1);
         SRC_TORQUE_ABS: r = frac_pct(TORQUE_FRAC, 2, 1);
         SRC_POWER: r = frac_pct(POWER_FRAC, 2, 1);
         SRC_VOLTAGE: r = frac_pct(VOLTAGE_FRAC, 6, 5);
         SRC_PULSE_IN: r = frac_pct(PULSE_IN_FRAC, 1, 1);
         SRC_AIN1: r = frac_pct(AIN1_FRAC, 1, 1);
         SRC_AIN2: r = frac_pct(AIN2_FRAC, 1, 1);
         SRC_AIN3: r = frac_pct(AIN3_FRAC, 1, 1);
         SRC_LENGTH: r = frac_pct(LENGTH_FRAC, 1, 1);
         SRC_COUNT: r = frac_pct(COUNT_FRAC, 1, 1);
         SRC_COMM: r = (COMM_PCT > SPAN_FULL) ? SPAN_FULL : COMM_PCT;
         SRC_SPEED: r = frac_pct(SPEED_FRAC, 1, 1);
         // absolute-unit codes: current and voltage fractions taken 1:1, full span at 1.0 times rated
         SRC_CURR_ABS: r = frac_pct(CURRENT_FRAC, 1, 1);
         SRC_VOLT_ABS: r = frac_pct(VOLTAGE_FRAC, 1, 1);
         SRC_TORQUE_SIGNED: begin
            // half span is zero torque; +-2x rated reaches the ends
            if (TORQUE_NEGATIVE) begin
               r = half - t;
            end else begin
               r = half + t;
            end
         end
         default: r = '0;
      endcase
      source_pct = r;
   endfunction : source_pct

   // settings are taken in one load so a half-written set never applies
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         sel_pulse <= SEL_PULSE_RESET;
         sel_ao1 <= SEL_AO1_RESET;
         sel_ao2 <= SEL_AO2_RESET;
      end else if (SETTINGS_LOAD) begin
         sel_pulse <= PULSE_SOURCE_SEL;
         sel_ao1 <= AO1_SOURCE_SEL;
         sel_ao2 <= AO2_SOURCE_SEL;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         pulse_max <= PULSE_MAX_RESET;
      end else if (SETTINGS_LOAD) begin
         if (PULSE_MAX_FREQ_SETTING < PULSE_FLOOR) begin
            pulse_max <= PULSE_FLOOR;
         end else if (PULSE_MAX_FREQ_SETTING > PULSE_CEIL) begin
            pulse_max <= PULSE_CEIL;
         end else begin
            pulse_max <= PULSE_MAX_FREQ_SETTING;
         end
      end
   end

   // out-of-range trims saturate rather than being rejected
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         gain1 <= GAIN_RESET;
         gain2 <= GAIN_RESET;
         offs1 <= OFFS_RESET;
         offs2 <= OFFS_RESET;
      end else if (SETTINGS_LOAD) begin
         gain1 <= (AO1_GAIN > GAIN_MAX) ? GAIN_MAX :
            (AO1_GAIN < GAIN_MIN) ? GAIN_MIN : AO1_GAIN;
         gain2 <= (AO2_GAIN > GAIN_MAX) ? GAIN_MAX :
            (AO2_GAIN < GAIN_MIN) ? GAIN_MIN : AO2_GAIN;
         offs1 <= (AO1_OFFSET > OFFS_MAX) ? OFFS_MAX :
            (AO1_OFFSET < OFFS_MIN) ? OFFS_MIN : AO1_OFFSET;
         offs2 <= (AO2_OFFSET > OFFS_MAX) ? OFFS_MAX :
            (AO2_OFFSET < OFFS_MIN) ? OFFS_MIN : AO2_OFFSET;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         polarity <= POLARITY_RESET;
      end else if (SETTINGS_LOAD) begin
         polarity <= OUTPUT_POLARITY_SETTING;
      end
   end

   for (genvar i = 0; i < NTERM; i++) begin : g_delay_reg
      always_ff @(posedge CLK) begin
         if (!RSTN) begin
            delay[i] <= DELAY_RESET;
         end else if (SETTINGS_LOAD) begin
            delay[i] <= TERM_DELAY[16*i +: 16];
         end
      end
   end

   // source selection, registered
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         pct_pulse <= '0;
         pct_ao1 <= '0;
         pct_ao2 <= '0;
      end else begin
         pct_pulse <= source_pct(sel_pulse);
         pct_ao1 <= source_pct(sel_ao1);
         pct_ao2 <= source_pct(sel_ao2);
      end
   end

   // pulse frequency: floor + pct * (max - floor)
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         PULSE_FREQ_OUTPUT <= PULSE_FLOOR;
      end else begin
         PULSE_FREQ_OUTPUT <= PULSE_FLOOR + 14'((28'(pct_pulse)
            * 28'(pulse_max - PULSE_FLOOR)) / 28'(SPAN_FULL));
      end
   end

   analog_trim u_trim1 (
      .clk(CLK),
      .rstn(RSTN),
      .std_pct(pct_ao1),
      .gain(gain1),
      .offs(offs1),
      .out_pct(ANALOG_OUT_FIRST)
   );

   analog_trim u_trim2 (
      .clk(CLK),
      .rstn(RSTN),
      .std_pct(pct_ao2),
      .gain(gain2),
      .offs(offs2),
      .out_pct(ANALOG_OUT_SECOND)
   );

   // 0.1 s tick; one shared divider keeps five delays cheap
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         tenth_count <= '0;
      end else if (tenth_count == 27'(TENTH_CYCLES - 1)) begin
         tenth_count <= '0;
      end else begin
         tenth_count <= tenth_count + 27'h0000001;
      end
   end
   assign tick = tenth_count == 27'(TENTH_CYCLES - 1);

   for (genvar i = 0; i < NTERM; i++) begin : g_term
      terminal_delay u_delay (
         .clk(CLK),
         .rstn(RSTN),
         .tick(tick),
         .func_in(TERM_FUNC[i]),
         .delay(delay[i]),
         .func_out(func_delayed[i])
      );
      always_ff @(posedge CLK) begin
         if (!RSTN) begin
            TERM_CLOSED[i] <= 1'b0;
         end else begin
            // polarity after delay: delay counts function, not contact
            TERM_CLOSED[i] <= func_delayed[i] ^ polarity[i];
         end
      end
   end

   sequence s_loaded_pulse_max;
      SETTINGS_LOAD ##1 1'b1;
   endsequence
   a_pulse_floor: assert property (@(posedge CLK) disable iff (!RSTN)
      PULSE_FREQ_OUTPUT >= PULSE_FLOOR
      && PULSE_FREQ_OUTPUT <= $past(pulse_max))
      else $error("pulse frequency out of span");
   a_pulse_max_range: assert property (@(posedge CLK) disable iff (!RSTN)
      s_loaded_pulse_max |-> pulse_max >= PULSE_FLOOR
      && pulse_max <= PULSE_CEIL) else $error("pulse max out of range");
   a_gain_range: assert property (@(posedge CLK) disable iff (!RSTN)
      gain1 <= GAIN_MAX && gain1 >= GAIN_MIN && offs1 <= OFFS_MAX
      && offs1 >= OFFS_MIN) else $error("trim setting out of range");
   a_comm_pass: assert property (@(posedge CLK) disable iff (!RSTN)
      (sel_ao1 == 5'h0C && COMM_PCT <= SPAN_FULL && $stable(sel_ao1))
      |=> pct_ao1 == $past(COMM_PCT)) else $error("comm value not passed");
   a_polarity_map: assert property (@(posedge CLK) disable iff (!RSTN)
      1'b1 |=> TERM_CLOSED == ($past(func_delayed) ^ $past(polarity)))
      else $error("contact state wrong for polarity");
   a_polarity_reset: assert property (@(posedge CLK)
      !RSTN |=> polarity == 5'h00 && sel_ao2 == 5'h01)
      else $error("reset defaults wrong");
endmodule : output_conditioning

/* File: verif/field_wiring.sv */
// field side model: pulled-up contact terminals and an analog voltmeter
`timescale 1ns/1ns
module field_wiring (
   input wire logic [4:0] term_closed,
   input wire logic [13:0] ao_volts,
   output logic [4:0] contact_level,
   output logic [13:0] meter_mv
);
   // an open contact floats up to the pull-up, a closed one sits at common
   assign contact_level = ~term_closed;
   // voltage mode only: full span 10000 reads 10 V, one count per millivolt
   assign meter_mv = ao_volts;
endmodule : field_wiring

/* File: verif/drive_output_terminal_conditioning_bench.sv */
// self-checking bench for the output-terminal conditioning block
`timescale 1ns/1ns
module drive_output_terminal_conditioning_bench;
   import outcond_pkg::*;
   // outputs trail their inputs by three edges; two spare for margin
   localparam int SETTLE = 5;
   localparam logic [17:0] FRAC_INIT [0:12] = '{18'h01000, 18'h02000,
      18'h06000, 18'h08000, 18'h0A000, 18'h0C000, 18'h07000, 18'h08000,
      18'h09000, 18'h0A000, 18'h0B000, 18'h0C000, 18'h0E000};
   localparam logic [13:0] AO_EXP [0:16] = '{14'h0271, 14'h04E2, 14'h0753,
      14'h09C4, 14'h0C35, 14'h186A, 14'h1117, 14'h1388, 14'h15F9, 14'h186A,
      14'h1ADB, 14'h1D4C, 14'h0D05, 14'h222E, 14'h0EA6, 14'h1D4C, 14'h186A};
   localparam logic [13:0] PMAX_T [0:3] = '{14'h0001, 14'h2710, 14'h3FFF,
      14'h0000};
   localparam logic [13:0] PEXP_T [0:3] = '{14'h0001, 14'h2710, 14'h2710,
      14'h0001};
   localparam logic [11:0] G_T [0:6] = '{12'hFCE, 12'hFCE, 12'h0C8, 12'hF9C,
      12'h000, 12'h064, 12'h7FF};
   localparam logic [10:0] O_T [0:6] = '{11'h320, 11'h320, 11'h000, 11'h000,
      11'h3FF, 11'h418, 11'h000};
   localparam logic [17:0] R_T [0:6] = '{18'h00000, 18'h10000, 18'h0C000,
      18'h08000, 18'h00000, 18'h10000, 18'h01000};
   localparam logic [13:0] E_T [0:6] = '{14'h1F40, 14'h0BB8, 14'h2710,
      14'h0000, 14'h2710, 14'h0000, 14'h186A};
   localparam logic [4:0] POL_T [0:2] = '{5'h00, 5'h1F, 5'h15};
   localparam logic [4:0] FUNC_T [0:2] = '{5'h00, 5'h0A, 5'h1F};
   logic CLK = 1'b0;
   logic RSTN = 1'b0;
   logic [4:0] PULSE_SOURCE_SEL = 5'h00;
   logic [4:0] AO1_SOURCE_SEL = 5'h00;
   logic [4:0] AO2_SOURCE_SEL = 5'h01;
   logic [13:0] PULSE_MAX_FREQ_SETTING = 14'h1388;
   logic signed [11:0] AO1_GAIN = 12'h064;
   logic signed [11:0] AO2_GAIN = 12'h064;
   logic signed [10:0] AO1_OFFSET = 11'h000;
   logic signed [10:0] AO2_OFFSET = 11'h000;
   logic [79:0] TERM_DELAY = 80'h0;
   logic [4:0] OUTPUT_POLARITY_SETTING = 5'h00;
   logic SETTINGS_LOAD = 1'b0;
   logic [17:0] frac [0:12] = FRAC_INIT;
   logic torque_negative = 1'b0;
   logic [13:0] COMM_PCT = 14'h0D05;
   logic [4:0] TERM_FUNC = 5'h00;
   logic [13:0] PULSE_FREQ_OUTPUT;
   logic [13:0] ANALOG_OUT_FIRST;
   logic [13:0] ANALOG_OUT_SECOND;
   logic [4:0] TERM_CLOSED;
   logic [4:0] contact_level;
   logic [13:0] meter_mv;
   int miscompares = 0;
   int total_checks = 0;

   output_conditioning u_dut (
      .CLK(CLK), .RSTN(RSTN), .PULSE_SOURCE_SEL(PULSE_SOURCE_SEL),
      .AO1_SOURCE_SEL(AO1_SOURCE_SEL), .AO2_SOURCE_SEL(AO2_SOURCE_SEL),
      .PULSE_MAX_FREQ_SETTING(PULSE_MAX_FREQ_SETTING),
      .AO1_GAIN(AO1_GAIN), .AO2_GAIN(AO2_GAIN),
      .AO1_OFFSET(AO1_OFFSET), .AO2_OFFSET(AO2_OFFSET),
      .TERM_DELAY(TERM_DELAY),
      .OUTPUT_POLARITY_SETTING(OUTPUT_POLARITY_SETTING),
      .SETTINGS_LOAD(SETTINGS_LOAD), .RUN_FREQ_FRAC(frac[0]),
      .SET_FREQ_FRAC(frac[1]), .CURRENT_FRAC(frac[2]),
      .TORQUE_FRAC(frac[3]), .TORQUE_NEGATIVE(torque_negative),
      .POWER_FRAC(frac[4]), .VOLTAGE_FRAC(frac[5]),
      .PULSE_IN_FRAC(frac[6]), .AIN1_FRAC(frac[7]), .AIN2_FRAC(frac[8]),
      .AIN3_FRAC(frac[9]), .LENGTH_FRAC(frac[10]), .COUNT_FRAC(frac[11]),
      .COMM_PCT(COMM_PCT), .SPEED_FRAC(frac[12]), .TERM_FUNC(TERM_FUNC),
      .PULSE_FREQ_OUTPUT(PULSE_FREQ_OUTPUT),
      .ANALOG_OUT_FIRST(ANALOG_OUT_FIRST),
      .ANALOG_OUT_SECOND(ANALOG_OUT_SECOND), .TERM_CLOSED(TERM_CLOSED)
   );

   field_wiring u_field (
      .term_closed(TERM_CLOSED),
      .ao_volts(ANALOG_OUT_FIRST),
      .contact_level(contact_level),
      .meter_mv(meter_mv)
   );

   always #5 CLK = ~CLK;

   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
   endtask : tick

   // settings staged by the caller at this edge are taken on the next one
   task automatic load();
      SETTINGS_LOAD <= 1'b1;
      @(posedge CLK);
      SETTINGS_LOAD <= 1'b0;
      tick(SETTLE);
   endtask : load

   task automatic cmp14(input string what, input logic [13:0] exp,
                        input logic [13:0] got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %0d seen %0d", what, exp, got);
      end
   endtask : cmp14

   task automatic cmp5(input string what, input logic [4:0] exp,
                       input logic [4:0] got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask : cmp5

   task automatic test_done();
      if (miscompares == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : test_done

   initial begin
      // sampled in the edge's active region: values from before that edge
      tick(2);
      cmp14("pulse in reset", 14'h0001, PULSE_FREQ_OUTPUT);
      cmp14("ao1 in reset", 14'h0000, ANALOG_OUT_FIRST);
      cmp5("terms in reset", 5'h00, TERM_CLOSED);
      RSTN <= 1'b1;
      tick(SETTLE + 1);
      cmp14("ao1 default", AO_EXP[0], ANALOG_OUT_FIRST);
      cmp14("ao2 default", AO_EXP[1], ANALOG_OUT_SECOND);
      // second output walks the codes backwards so the two stay independent
      for (int c = 0; c <= 16; c++) begin
         AO1_SOURCE_SEL <= 5'(c);
         AO2_SOURCE_SEL <= 5'(16 - c);
         load();
         cmp14("ao1 src", AO_EXP[c], ANALOG_OUT_FIRST);
         cmp14("ao2 src", AO_EXP[16 - c], ANALOG_OUT_SECOND);
      end
      torque_negative <= 1'b1;
      tick(SETTLE);
      cmp14("ao1 neg torque", 14'h0EA6, ANALOG_OUT_FIRST);
      PULSE_SOURCE_SEL <= 5'h0C;
      for (int i = 0; i < 4; i++) begin
         PULSE_MAX_FREQ_SETTING <= PMAX_T[i];
         COMM_PCT <= 14'h2710;
         load();
         cmp14("pulse full", PEXP_T[i], PULSE_FREQ_OUTPUT);
         COMM_PCT <= 14'h0000;
         tick(SETTLE);
         cmp14("pulse floor", 14'h0001, PULSE_FREQ_OUTPUT);
      end
      AO1_SOURCE_SEL <= 5'h00;
      AO2_SOURCE_SEL <= 5'h00;
      for (int i = 0; i < 7; i++) begin
         AO1_GAIN <= G_T[i];
         AO2_GAIN <= G_T[i];
         AO1_OFFSET <= O_T[i];
         AO2_OFFSET <= O_T[i];
         frac[0] <= R_T[i];
         load();
         cmp14("ao1 trim", E_T[i], ANALOG_OUT_FIRST);
         cmp14("ao2 trim", E_T[i], ANALOG_OUT_SECOND);
         cmp14("meter", E_T[i], meter_mv);
      end
      for (int p = 0; p < 3; p++) begin
         OUTPUT_POLARITY_SETTING <= POL_T[p];
         load();
         for (int f = 0; f < 3; f++) begin
            TERM_FUNC <= FUNC_T[f];
            tick(SETTLE);
            cmp5("contacts", FUNC_T[f] ^ POL_T[p], TERM_CLOSED);
            cmp5("level", ~(FUNC_T[f] ^ POL_T[p]), contact_level);
         end
      end
      OUTPUT_POLARITY_SETTING <= 5'h00;
      TERM_FUNC <= 5'h00;
      load();
      // relay one waits two tenths; a tick cannot arrive within 100 cycles
      TERM_DELAY[16 +: 16] <= 16'h0002;
      load();
      TERM_FUNC <= 5'h1F;
      tick(100);
      cmp5("delayed contact", 5'h1D, TERM_CLOSED);
      OUTPUT_POLARITY_SETTING <= 5'h02;
      load();
      cmp5("inverted pending", 5'h1F, TERM_CLOSED);
      RSTN <= 1'b0;
      frac[0] <= 18'h10000;
      tick(2);
      cmp5("terms in reset", 5'h00, TERM_CLOSED);
      RSTN <= 1'b1;
      tick(SETTLE + 1);
      cmp14("pulse default max", 14'h1388, PULSE_FREQ_OUTPUT);
      cmp14("ao1 default trim", 14'h2710, ANALOG_OUT_FIRST);
      cmp5("default delay", 5'h1F, TERM_CLOSED);
      test_done();
   end
endmodule : drive_output_terminal_conditioning_bench
